// ===== design/scan_tap_pkg.sv
// Constants and types shared by the boundary-scan test port
package scan_tap_pkg;

  // ------------------------------------------------------------
  // Register sizes
  // ------------------------------------------------------------
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_W = 107;
  // One-based cell 48 has no pad behind it
  localparam int INTERNAL_CELL = 47;

  // ------------------------------------------------------------
  // Instruction codes (instruction_bit_two..instruction_bit_zero)
  // ------------------------------------------------------------
  localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
  // Fixed pattern loaded on instruction capture
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

  // ------------------------------------------------------------
  // Identification word fields
  // ------------------------------------------------------------
  // Arbitrary values, not those of any real part
  localparam logic [2:0] ID_REVISION = 3'h2;
  localparam logic [16:0] ID_PART_CFG = 17'h0A5A5;
  localparam logic [10:0] ID_MAKER = 11'h2B5;
  localparam logic ID_START_BIT = 1'h1;
  localparam logic [ID_W-1:0] ID_VALUE = {ID_REVISION, ID_PART_CFG, ID_MAKER, ID_START_BIT};

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic BYP_RST = 1'h0;
  localparam logic TDO_RST = 1'h0;
  localparam logic TDO_OE_N_RST = 1'h1;
  localparam logic [ID_W-1:0] ID_RST = 32'h0;
  localparam logic [BSR_W-1:0] BSR_RST = 107'h0;

  // ------------------------------------------------------------
  // TAP controller states
  // ------------------------------------------------------------
  typedef enum logic [15:0] {
    ST_TLR = 16'h0001,
    ST_RTI = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PA_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PA_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } tap_state_t;

endpackage

// ===== design/level_sync.sv
// Two-flop level synchroniser with a constant reset value
`timescale 1ns/1ns
`default_nettype none

module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_t;

  sync_t q;
  sync_t d;

  // First stage feeds only the second stage
  always_comb begin
    d = q;
    d.meta = i_d;
    d.stable = q.meta;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= {RST_VAL, RST_VAL};
    end else begin
      q <= d;
    end
  end

  assign o_q = q.stable;

endmodule

`default_nettype wire

// ===== design/sram_boundary_scan_tap.sv
// Boundary-scan test access port: TAP controller, instruction, bypass, ID and pad chain
`timescale 1ns/1ns
`default_nettype none

// Operation
// - A sixteen-state TAP controller resets itself at power-up with no separate test reset pin.
// - An undriven test mode select or test data input behaves as a logic one; the module has no pull-ups, so I_TMS and I_TDI must be driven.
// - Scan only watches the package pads and never shifts memory array contents out.
// - Instruction register is 3 bits, bypass 1 bit, identification 32 bits, pad chain 107 cells.
// - Code 000 selects the pad chain and forces the data outputs to high impedance.
// - Code 010 selects the pad chain and forces the data outputs to high impedance.
// - Code 100 selects the pad chain and leaves the data outputs driven normally.
// - Code 001 places the identification register on the scan path with test data in at its head.
// - Code 111 selects the bypass bit, which is cleared when the instruction takes effect.
// - The bypass bit keeps the last shifted-in value after the data shift state is left.
// - The identification word holds revision, part configuration, maker code and a start one.
// - The pad chain has a fixed order, cell 48 is internal and unconnected pads are don't-care.
// - The pads are watched by the scan chain whenever test mode is active; the chain captures them only in Capture-DR under codes 000, 010 and 100.
module sram_boundary_scan_tap (
  input wire logic I_SYS_CLK,
  input wire logic I_ARST_N,
  input wire logic I_TCK,
  input wire logic I_TMS,
  input wire logic I_TDI,
  input wire logic [scan_tap_pkg::BSR_W-1:0] I_PAD,
  output logic O_TDO,
  output logic O_TDO_OE_N,
  output logic O_PAD_HIZ
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    scan_tap_pkg::tap_state_t st;
    logic [scan_tap_pkg::IR_W-1:0] ir_sh;
    logic [scan_tap_pkg::IR_W-1:0] ir;
    logic byp;
    logic [scan_tap_pkg::ID_W-1:0] id_sh;
    logic [scan_tap_pkg::BSR_W-1:0] bsr;
    logic hiz;
  } tap_regs_t;

  typedef struct packed {
    logic tdo;
    logic oe_n;
  } tdo_regs_t;

  tap_regs_t q;
  tap_regs_t d;
  tdo_regs_t nq;
  tdo_regs_t nd;
  logic rst_tck_n;
  logic [scan_tap_pkg::BSR_W-1:0] pad_s;
  logic [scan_tap_pkg::BSR_W-1:0] bsr_cap;
  logic sel_id;
  logic sel_bsr;
  logic in_shift;
  logic tdo_bit;

  // ------------------------------------------------------------
  // Crossings
  // ------------------------------------------------------------
  // Power-up reset asserts at once, releases on the test clock
  level_sync #(.WIDTH(1), .RST_VAL(1'h0)) u_rst_sync (
    .i_clk(I_TCK),
    .i_rst_n(I_ARST_N),
    .i_d(1'h1),
    .o_q(rst_tck_n)
  );

  // Pads are asynchronous to the test clock
  level_sync #(.WIDTH(scan_tap_pkg::BSR_W), .RST_VAL(scan_tap_pkg::BSR_RST)) u_pad_sync (
    .i_clk(I_TCK),
    .i_rst_n(rst_tck_n),
    .i_d(I_PAD),
    .o_q(pad_s)
  );

  // Output disable is a level, handed to the memory clock domain
  level_sync #(.WIDTH(1), .RST_VAL(1'h0)) u_hiz_sync (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_ARST_N),
    .i_d(q.hiz),
    .o_q(O_PAD_HIZ)
  );

  // ------------------------------------------------------------
  // Instruction decode
  // ------------------------------------------------------------
  always_comb begin
    sel_id = (q.ir == scan_tap_pkg::INS_IDCODE);
    sel_bsr = (q.ir == scan_tap_pkg::INS_EXTEST) ||
              (q.ir == scan_tap_pkg::INS_SAMPLE_Z) ||
              (q.ir == scan_tap_pkg::INS_SAMPLE);
    // Reserved codes fall back to the bypass bit as a harmless path
    in_shift = (q.st == scan_tap_pkg::ST_SH_DR) || (q.st == scan_tap_pkg::ST_SH_IR);
    // Only pad levels are captured, never array data
    bsr_cap = pad_s;
    bsr_cap[scan_tap_pkg::INTERNAL_CELL] = 1'h0;
  end

  // ------------------------------------------------------------
  // TAP controller and scan registers
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    case (q.st)
      scan_tap_pkg::ST_TLR: begin
        d.st = I_TMS ? scan_tap_pkg::ST_TLR : scan_tap_pkg::ST_RTI;
      end
      scan_tap_pkg::ST_RTI: begin
        d.st = I_TMS ? scan_tap_pkg::ST_SEL_DR : scan_tap_pkg::ST_RTI;
      end
      scan_tap_pkg::ST_SEL_DR: begin
        d.st = I_TMS ? scan_tap_pkg::ST_SEL_IR : scan_tap_pkg::ST_CAP_DR;
      end
      scan_tap_pkg::ST_CAP_DR: begin
        d.st = I_TMS ? scan_tap_pkg::ST_EX1_DR : scan_tap_pkg::ST_SH_DR;
      end
      scan_tap_pkg::ST_SH_DR: begin
        d.st = I_TMS ? scan_tap_pkg::ST_EX1_DR : scan_tap_pkg::ST_SH_DR;
      end
      scan_tap_pkg::ST_EX1_DR: begin
        d.st = I_TMS ? scan_tap_pkg::ST_UPD_DR : scan_tap_pkg::ST_PA_DR;
      end
      scan_tap_pkg::ST_PA_DR: begin
        d.st = I_TMS ? scan_tap_pkg::ST_EX2_DR : scan_tap_pkg::ST_PA_DR;
      end
      scan_tap_pkg::ST_EX2_DR: begin
        d.st = I_TMS ? scan_tap_pkg::ST_UPD_DR : scan_tap_pkg::ST_SH_DR;
      end
      scan_tap_pkg::ST_UPD_DR: begin
        d.st = I_TMS ? scan_tap_pkg::ST_SEL_DR : scan_tap_pkg::ST_RTI;
      end
      scan_tap_pkg::ST_SEL_IR: begin
        d.st = I_TMS ? scan_tap_pkg::ST_TLR : scan_tap_pkg::ST_CAP_IR;
      end
      scan_tap_pkg::ST_CAP_IR: begin
        d.st = I_TMS ? scan_tap_pkg::ST_EX1_IR : scan_tap_pkg::ST_SH_IR;
      end
      scan_tap_pkg::ST_SH_IR: begin
        d.st = I_TMS ? scan_tap_pkg::ST_EX1_IR : scan_tap_pkg::ST_SH_IR;
      end
      scan_tap_pkg::ST_EX1_IR: begin
        d.st = I_TMS ? scan_tap_pkg::ST_UPD_IR : scan_tap_pkg::ST_PA_IR;
      end
      scan_tap_pkg::ST_PA_IR: begin
        d.st = I_TMS ? scan_tap_pkg::ST_EX2_IR : scan_tap_pkg::ST_PA_IR;
      end
      scan_tap_pkg::ST_EX2_IR: begin
        d.st = I_TMS ? scan_tap_pkg::ST_UPD_IR : scan_tap_pkg::ST_SH_IR;
      end
      scan_tap_pkg::ST_UPD_IR: begin
        d.st = I_TMS ? scan_tap_pkg::ST_SEL_DR : scan_tap_pkg::ST_RTI;
      end
      default: begin
        d.st = scan_tap_pkg::ST_TLR;
      end
    endcase

    case (q.st)
      scan_tap_pkg::ST_TLR: begin
        d.ir = scan_tap_pkg::INS_IDCODE;
      end
      scan_tap_pkg::ST_CAP_IR: begin
        d.ir_sh = scan_tap_pkg::IR_CAPTURE;
      end
      scan_tap_pkg::ST_SH_IR: begin
        d.ir_sh = {I_TDI, q.ir_sh[scan_tap_pkg::IR_W-1:1]};
      end
      scan_tap_pkg::ST_UPD_IR: begin
        d.ir = q.ir_sh;
        if (q.ir_sh == scan_tap_pkg::INS_BYPASS) begin
          d.byp = 1'h0;
        end
      end
      scan_tap_pkg::ST_CAP_DR: begin
        if (sel_id) begin
          d.id_sh = scan_tap_pkg::ID_VALUE;
        end else if (sel_bsr) begin
          d.bsr = bsr_cap;
        end
      end
      scan_tap_pkg::ST_SH_DR: begin
        if (sel_id) begin
          d.id_sh = {I_TDI, q.id_sh[scan_tap_pkg::ID_W-1:1]};
        end else if (sel_bsr) begin
          d.bsr = {I_TDI, q.bsr[scan_tap_pkg::BSR_W-1:1]};
        end else begin
          // Only an update to BYPASS also touches the bit, so it holds on exit
          d.byp = I_TDI;
        end
      end
      default: begin
      end
    endcase

    // Follows the instruction in force, including after reset
    d.hiz = (d.ir == scan_tap_pkg::INS_EXTEST) || (d.ir == scan_tap_pkg::INS_SAMPLE_Z);
  end

  // With the test clock held low nothing here moves
  always_ff @(posedge I_TCK or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      q.st <= scan_tap_pkg::ST_TLR;
      q.ir_sh <= scan_tap_pkg::IR_CAPTURE;
      q.ir <= scan_tap_pkg::INS_IDCODE;
      q.byp <= scan_tap_pkg::BYP_RST;
      q.id_sh <= scan_tap_pkg::ID_RST;
      q.bsr <= scan_tap_pkg::BSR_RST;
      q.hiz <= 1'h0;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Test data out on the falling edge
  // ------------------------------------------------------------
  always_comb begin
    if (q.st == scan_tap_pkg::ST_SH_IR) begin
      tdo_bit = q.ir_sh[0];
    end else if (sel_id) begin
      tdo_bit = q.id_sh[0];
    end else if (sel_bsr) begin
      tdo_bit = q.bsr[0];
    end else begin
      tdo_bit = q.byp;
    end
    nd = nq;
    nd.oe_n = !in_shift;
    if (in_shift) begin
      nd.tdo = tdo_bit;
    end
  end

  // Half a cycle of setup for the tester's next rising edge
  always_ff @(negedge I_TCK or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      nq.tdo <= scan_tap_pkg::TDO_RST;
      nq.oe_n <= scan_tap_pkg::TDO_OE_N_RST;
    end else begin
      nq <= nd;
    end
  end

  assign O_TDO = nq.tdo;
  assign O_TDO_OE_N = nq.oe_n;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Floating inputs read as one on the board; the module itself has no pull-ups
  sequence s_tms_high5;
    I_TMS [*5];
  endsequence

  sequence s_byp_exit;
    (q.st == scan_tap_pkg::ST_SH_DR) && (q.ir == scan_tap_pkg::INS_BYPASS) && I_TMS;
  endsequence

  default clocking cb @(posedge I_TCK);
  endclocking

  default disable iff (!rst_tck_n);

  a_tms_ones_reset: assert property (s_tms_high5 |=> q.st == scan_tap_pkg::ST_TLR)
    else $error("five ones on mode select did not reach reset state");

  a_idle_entry: assert property (
    (q.st == scan_tap_pkg::ST_TLR) && !I_TMS |=> q.st == scan_tap_pkg::ST_RTI)
    else $error("reset state did not move to idle");

  a_reset_idcode: assert property (
    q.st == scan_tap_pkg::ST_TLR |=> q.ir == scan_tap_pkg::INS_IDCODE)
    else $error("identification instruction not selected in reset state");

  a_ir_update: assert property (
    q.st == scan_tap_pkg::ST_UPD_IR |=> q.ir == $past(q.ir_sh))
    else $error("instruction not taken on update");

  a_byp_clear: assert property (
    (q.st == scan_tap_pkg::ST_UPD_IR) && (q.ir_sh == scan_tap_pkg::INS_BYPASS)
    |=> q.byp == 1'h0)
    else $error("bypass bit not cleared on instruction");

  a_byp_hold_exit: assert property (
    s_byp_exit |=> (q.byp == $past(I_TDI)) ##1 (q.byp == $past(q.byp)))
    else $error("bypass bit lost on leaving shift");

  a_hiz_select: assert property (
    ((q.ir == scan_tap_pkg::INS_EXTEST) || (q.ir == scan_tap_pkg::INS_SAMPLE_Z)) |-> q.hiz)
    else $error("outputs not forced off under pad test");

  a_sample_driven: assert property (
    (q.ir == scan_tap_pkg::INS_SAMPLE) |-> !q.hiz)
    else $error("outputs forced off under sample");

  a_id_capture: assert property (
    (q.st == scan_tap_pkg::ST_CAP_DR) && sel_id |=> q.id_sh == scan_tap_pkg::ID_VALUE)
    else $error("identification word not captured");

  a_id_shift_in: assert property (
    (q.st == scan_tap_pkg::ST_SH_DR) && sel_id |=> q.id_sh[scan_tap_pkg::ID_W-1] == $past(I_TDI))
    else $error("test data in not entering identification register");

  a_pad_capture: assert property (
    (q.st == scan_tap_pkg::ST_CAP_DR) && sel_bsr
    |=> (q.bsr[0] == $past(pad_s[0])) && (q.bsr[scan_tap_pkg::INTERNAL_CELL] == 1'h0))
    else $error("pad chain capture wrong");

  a_tdo_drive: assert property (in_shift |-> !O_TDO_OE_N)
    else $error("test data out not driven in shift");

  a_tdo_float: assert property (!in_shift |-> O_TDO_OE_N)
    else $error("test data out driven outside shift");

endmodule

`default_nettype wire

// ===== dv/scan_tester.sv
// Model of the external scan tester that drives the test port
`timescale 1ns/1ns
`default_nettype none

module scan_tester (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo,
  input wire logic i_tdo_oe_n
);
  // ------------------------------------------------------------
  // Idle levels
  // ------------------------------------------------------------
  initial begin
    o_tck = 1'h0; // Clock stands low outside frames
    o_tms = 1'h1; // Idle at the pulled-up level
    o_tdi = 1'h1;
  end

  // ------------------------------------------------------------
  // Frame tasks
  // ------------------------------------------------------------
  // One 12 ns test clock; inputs change after the falling edge
  task automatic tick(input logic tms, input logic tdi, output logic tdo, output logic oe_n);
    o_tms <= tms;
    o_tdi <= tdi;
    #6;
    tdo = i_tdo; // Taken at the rising edge
    oe_n = i_tdo_oe_n;
    o_tck = 1'h1;
    #6;
    o_tck = 1'h0;
  endtask

  task automatic idle_to_shift(input logic ir);
    logic d;
    logic o;
    tick(1'h1, 1'h1, d, o);
    if (ir) begin
      tick(1'h1, 1'h1, d, o);
    end
    tick(1'h0, 1'h1, d, o);
    tick(1'h0, 1'h1, d, o);
  endtask

  // LSB first, then through Update back to idle
  task automatic shift(input int n, input logic [127:0] din, output logic [127:0] dout,
                       output logic oe_low);
    logic d;
    logic o;
    dout = '0;
    oe_low = 1'h1;
    for (int i = 0; i < n; i++) begin
      tick(logic'(i == n - 1), din[i], d, o);
      dout[i] = d;
      oe_low = oe_low & (o === 1'h0);
    end
    tick(1'h1, 1'h1, d, o);
    tick(1'h0, 1'h1, d, o);
  endtask

  task automatic reset_tap();
    logic d;
    logic o;
    for (int i = 0; i < 5; i++) begin
      tick(1'h1, 1'h1, d, o);
    end
    tick(1'h0, 1'h1, d, o);
  endtask

  // Callers pass only defined codes
  task automatic load_ir(input logic [2:0] code, output logic [127:0] dout, output logic oe_low);
    idle_to_shift(1'h1);
    shift(3, {125'h0, code}, dout, oe_low);
  endtask

  task automatic scan_dr(input int n, input logic [127:0] din, output logic [127:0] dout,
                         output logic oe_low);
    idle_to_shift(1'h0);
    shift(n, din, dout, oe_low);
  endtask
endmodule

`default_nettype wire

// ===== dv/sram_boundary_scan_tap_tb.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ns
`default_nettype none

module sram_boundary_scan_tap_tb;
  logic sys_clk;
  logic arst_n;
  logic tck;
  logic tms;
  logic tdi;
  logic [scan_tap_pkg::BSR_W-1:0] pad;
  logic tdo;
  logic tdo_oe_n;
  logic pad_hiz;
  int err_count;
  int compares;
  int cycles;
  logic [127:0] got;
  logic oe_low;

  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end

  sram_boundary_scan_tap sram_boundary_scan_tap_inst (
    .I_SYS_CLK(sys_clk), .I_ARST_N(arst_n), .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi),
    .I_PAD(pad), .O_TDO(tdo), .O_TDO_OE_N(tdo_oe_n), .O_PAD_HIZ(pad_hiz)
  );

  scan_tester scan_tester_inst (
    .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo), .i_tdo_oe_n(tdo_oe_n)
  );

  // ------------------------------------------------------------
  // Checking and verdict
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] seen);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Whole run is well under 3000 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end

  // Lets the output-disable flag cross into the memory clock
  task automatic settle_sys();
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_idcode();
    logic [31:0] id;
    id = {scan_tap_pkg::ID_REVISION, scan_tap_pkg::ID_PART_CFG, scan_tap_pkg::ID_MAKER, 1'h1};
    scan_tester_inst.scan_dr(64, {96'h0, 32'hC3A50F96}, got, oe_low);
    chk("idcode", {64'h0, 32'hC3A50F96, id}, got);
    chk("shift_oe_n", 128'h1, 128'(oe_low));
    settle_sys();
    chk("idle_oe_n", 128'h1, 128'(tdo_oe_n));
    chk("pad_hiz", 128'h0, 128'(pad_hiz));
  endtask

  // Six bits through the instruction path; last three leave BYPASS in place
  task automatic test_bypass();
    scan_tester_inst.idle_to_shift(1'h1);
    scan_tester_inst.shift(6, {122'h0, 3'h7, 3'h5}, got, oe_low);
    chk("ir_length", {122'h0, 3'h5, scan_tap_pkg::IR_CAPTURE}, got);
    scan_tester_inst.scan_dr(8, 128'hB6, got, oe_low);
    chk("bypass_first", 128'h6C, got);
    scan_tester_inst.scan_dr(4, 128'h8, got, oe_low);
    chk("bypass_keep", 128'h1, got);
    scan_tester_inst.load_ir(scan_tap_pkg::INS_BYPASS, got, oe_low);
    scan_tester_inst.scan_dr(2, 128'h0, got, oe_low);
    chk("bypass_clear", 128'h0, got);
  endtask

  task automatic test_chain();
    logic [2:0] codes [3];
    logic [scan_tap_pkg::BSR_W-1:0] expb;
    codes = '{scan_tap_pkg::INS_SAMPLE, scan_tap_pkg::INS_EXTEST, scan_tap_pkg::INS_SAMPLE_Z};
    for (int c = 0; c < 3; c++) begin
      @(posedge sys_clk);
      pad <= ~pad;
      scan_tester_inst.load_ir(codes[c], got, oe_low);
      chk("ir_capture", 128'(scan_tap_pkg::IR_CAPTURE), got);
      settle_sys();
      chk("pad_hiz", 128'(codes[c] != 3'h4), 128'(pad_hiz));
      expb = pad;
      expb[scan_tap_pkg::INTERNAL_CELL] = 1'h0;
      scan_tester_inst.scan_dr(115, {120'h0, 8'hA7}, got, oe_low);
      chk("chain", {13'h0, 8'hA7, expb}, got);
    end
  endtask

  // Five ones from idle return to the identification instruction
  task automatic test_reset();
    scan_tester_inst.reset_tap();
    test_idcode();
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    err_count = 0;
    compares = 0;
    cycles = 0;
    // Late update so every reset process sees the falling edge
    arst_n <= 1'h0;
    for (int k = 0; k < scan_tap_pkg::BSR_W; k++) begin
      pad[k] = logic'(k % 3 == 0);
    end
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'h1;
    #3;
    scan_tester_inst.reset_tap();
    test_idcode();
    test_bypass();
    test_chain();
    test_reset();
    results();
  end
endmodule

`default_nettype wire
